/* File: design/gpdr_pin_cell.sv */
// Purpose: Bidirectional pin cells for one port, one cell per pin.
// Assumes: Pin levels are synchronous to the system clock.
// Notes: Output enable is active low.
`timescale 1ns/1ns
`default_nettype none
module gpdr_pin_cell #(
  parameter int PINS = 8
) (
  input wire logic [PINS-1:0] i_dir,
  input wire logic [PINS-1:0] i_latch,
  input wire logic [PINS-1:0] i_pin,
  output logic [PINS-1:0] o_pin,
  output logic [PINS-1:0] o_oe_n,
  output logic [PINS-1:0] o_read
);
  if (PINS < 1 || PINS > 8) begin : g_bad_width
    $error("pin cell width must be 1 to 8");
  end

  for (genvar b = 0; b < PINS; b++) begin : g_cell
    // Direction 1 drives the latch, 0 leaves the pin as input
    assign o_pin[b] = i_latch[b];
    assign o_oe_n[b] = ~i_dir[b];
    // Output pins read back the latch, inputs read the pin
    assign o_read[b] = i_dir[b] ? i_latch[b] : i_pin[b];
  end
endmodule
`default_nettype wire

/* File: design/gpdr_pkg.sv */
// Purpose: Constants and carrier types for the port data and direction registers.
// Assumes: APB slave with 32-bit data; one aligned word per register.
// Notes: Register indices are word indices; the byte address is four times the index.
// Operation
// - Port 9 direction: six write-only bits 5..0, reset zero; bits 7..6 read one.
// - Port 9 pin is input when its direction bit is 0, drives latch when 1.
// - Port A direction: eight write-only bits, reset zero, 0 input, 1 output.
// - Port A data register: eight read/write bits, cleared to zero on reset.
package gpdr_pkg;

  // ----------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_P7_LEVELS = 8'hce;
  localparam logic [7:0] IDX_P8_LATCH = 8'hcf;
  localparam logic [7:0] IDX_P9_DIR = 8'hd0;
  localparam logic [7:0] IDX_PA_DIR = 8'hd1;
  localparam logic [7:0] IDX_P9_LATCH = 8'hd2;
  localparam logic [7:0] IDX_PA_LATCH = 8'hd3;
  localparam logic [ADDR_W-1:0] ADDR_P7_LEVELS = {2'h0, IDX_P7_LEVELS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_P8_LATCH = {2'h0, IDX_P8_LATCH, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_P9_DIR = {2'h0, IDX_P9_DIR, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PA_DIR = {2'h0, IDX_PA_DIR, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_P9_LATCH = {2'h0, IDX_P9_LATCH, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PA_LATCH = {2'h0, IDX_PA_LATCH, 2'h0};

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int P8_PINS = 5;
  localparam int P9_PINS = 6;
  localparam int PA_PINS = 8;
  localparam logic [7:0] P8_LATCH_RST = 8'h00;
  localparam logic [7:0] P9_DIR_RST = 8'h00;
  localparam logic [7:0] P9_LATCH_RST = 8'h00;
  localparam logic [7:0] PA_DIR_RST = 8'h00;
  localparam logic [7:0] PA_LATCH_RST = 8'h00;
  localparam logic [7:0] UNUSED_BITS = 8'hff;
  localparam logic [7:0] WO_READ_VAL = 8'hff;

  // ----------------------------------------
  // Bus carriers
  // ----------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } gpdr_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } gpdr_apb_rsp_s;

endpackage

/* File: design/gpdr_ports.sv */
// Purpose: Ports 7, 8, 9 and A data and direction registers behind an APB slave.
// Assumes: Single clock; synchronous active-low reset; clock enable freezes state.
// Notes: With the clock enable high, every access ends in its first access cycle with no wait state; unmapped addresses answer with pslverr.
`timescale 1ns/1ns
`default_nettype none
module gpdr_ports #(
  parameter int P9_WIDTH = gpdr_pkg::P9_PINS,
  parameter int PA_WIDTH = gpdr_pkg::PA_PINS
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  input wire gpdr_pkg::gpdr_apb_req_s i_apb,
  output gpdr_pkg::gpdr_apb_rsp_s o_apb,
  input wire logic [7:0] i_p7_pins,
  output logic [gpdr_pkg::P8_PINS-1:0] o_p8_pins,
  input wire logic [P9_WIDTH-1:0] i_p9_pins,
  output logic [P9_WIDTH-1:0] o_p9_pins,
  output logic [P9_WIDTH-1:0] o_p9_oe_n,
  input wire logic [PA_WIDTH-1:0] i_pa_pins,
  output logic [PA_WIDTH-1:0] o_pa_pins,
  output logic [PA_WIDTH-1:0] o_pa_oe_n
);
  import gpdr_pkg::*;

  if (P9_WIDTH != P9_PINS || PA_WIDTH != PA_PINS) begin : g_bad_width
    $error("port widths are fixed by the register layout");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [P8_PINS-1:0] p8_latch_reg, p8_latch_next;
  logic [P9_WIDTH-1:0] p9_dir_reg, p9_dir_next;
  logic [P9_WIDTH-1:0] p9_latch_reg, p9_latch_next;
  logic [PA_WIDTH-1:0] pa_dir_reg, pa_dir_next;
  logic [PA_WIDTH-1:0] pa_latch_reg, pa_latch_next;
  logic [7:0] rdata_reg, rdata_next;
  logic err_reg, err_next;
  logic armed_reg, armed_next;
  logic [P9_WIDTH-1:0] p9_read;
  logic [PA_WIDTH-1:0] pa_read;
  logic setup, access, wr_done;
  logic [7:0] wbyte;

  // ----------------------------------------
  // Pin cells
  // ----------------------------------------
  gpdr_pin_cell #(.PINS(P9_WIDTH)) u_p9_cells (
    .i_dir(p9_dir_reg),
    .i_latch(p9_latch_reg),
    .i_pin(i_p9_pins),
    .o_pin(o_p9_pins),
    .o_oe_n(o_p9_oe_n),
    .o_read(p9_read)
  );

  gpdr_pin_cell #(.PINS(PA_WIDTH)) u_pa_cells (
    .i_dir(pa_dir_reg),
    .i_latch(pa_latch_reg),
    .i_pin(i_pa_pins),
    .o_pin(o_pa_pins),
    .o_oe_n(o_pa_oe_n),
    .o_read(pa_read)
  );

  assign o_p8_pins = p8_latch_reg;

  // ----------------------------------------
  // Bus phases
  // ----------------------------------------
  // Capture whenever no capture is pending, so a setup cycle lost to a low enable
  // is taken in the access cycle instead of hanging the transfer
  assign setup = i_clk_en & i_apb.psel & ~armed_reg;
  assign access = i_clk_en & i_apb.psel & i_apb.penable & armed_reg;
  assign wr_done = access & i_apb.pwrite & ~err_reg;
  assign wbyte = i_apb.pwdata[7:0];

  always_comb begin
    o_apb.pready = access;
    o_apb.pslverr = access & err_reg;
    o_apb.prdata = {24'h000000, rdata_reg};
  end

  // ----------------------------------------
  // Read capture in the setup cycle
  // ----------------------------------------
  always_comb begin
    rdata_next = rdata_reg;
    err_next = err_reg;
    armed_next = armed_reg;
    if (access) begin
      armed_next = 1'b0;
    end
    if (setup) begin
      armed_next = 1'b1;
      err_next = 1'b0;
      rdata_next = 8'h00;
      case (i_apb.paddr)
        ADDR_P7_LEVELS: rdata_next = i_p7_pins;
        ADDR_P8_LATCH: rdata_next = {UNUSED_BITS[7:P8_PINS], p8_latch_reg};
        ADDR_P9_DIR: rdata_next = WO_READ_VAL;
        ADDR_PA_DIR: rdata_next = WO_READ_VAL;
        ADDR_P9_LATCH: rdata_next = {UNUSED_BITS[7:P9_PINS], p9_read};
        ADDR_PA_LATCH: rdata_next = pa_read;
        default: err_next = 1'b1;
      endcase
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_comb begin
    p8_latch_next = p8_latch_reg;
    p9_dir_next = p9_dir_reg;
    p9_latch_next = p9_latch_reg;
    pa_dir_next = pa_dir_reg;
    pa_latch_next = pa_latch_reg;
    if (wr_done) begin
      case (i_apb.paddr)
        ADDR_P8_LATCH: p8_latch_next = wbyte[P8_PINS-1:0];
        ADDR_P9_DIR: p9_dir_next = wbyte[P9_PINS-1:0];
        ADDR_PA_DIR: pa_dir_next = wbyte;
        ADDR_P9_LATCH: p9_latch_next = wbyte[P9_PINS-1:0];
        ADDR_PA_LATCH: pa_latch_next = wbyte;
        default: p8_latch_next = p8_latch_reg;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      p8_latch_reg <= P8_LATCH_RST[P8_PINS-1:0];
      p9_dir_reg <= P9_DIR_RST[P9_PINS-1:0];
      p9_latch_reg <= P9_LATCH_RST[P9_PINS-1:0];
      pa_dir_reg <= PA_DIR_RST;
      pa_latch_reg <= PA_LATCH_RST;
      rdata_reg <= 8'h00;
      err_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else if (i_clk_en) begin
      p8_latch_reg <= p8_latch_next;
      p9_dir_reg <= p9_dir_next;
      p9_latch_reg <= p9_latch_next;
      pa_dir_reg <= pa_dir_next;
      pa_latch_reg <= pa_latch_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
      armed_reg <= armed_next;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);

  a_p9_dir_reset: assert property ($past(i_nrst) == 1'b0 |-> p9_dir_reg == 6'h00 && o_p9_oe_n == 6'h3f)
    else $error("port 9 direction not cleared by reset");

  a_p9_dir_write: assert property (wr_done && i_apb.paddr == ADDR_P9_DIR
    |=> p9_dir_reg == $past(i_apb.pwdata[5:0]))
    else $error("port 9 direction write lost");

  a_p9_dir_readback: assert property (setup && i_apb.paddr == ADDR_P9_DIR
    |=> o_apb.prdata[7:0] == 8'hff)
    else $error("port 9 direction read not all ones");

  a_p9_pin_drive: assert property (wr_done && i_apb.paddr == ADDR_P9_DIR && i_apb.pwdata[0]
    |=> !o_p9_oe_n[0] && o_p9_pins[0] == p9_latch_reg[0])
    else $error("port 9 pin 0 not driven after direction set");

  a_p9_pin_input: assert property (p9_dir_reg[1] == 1'b0 |-> o_p9_oe_n[1] && p9_read[1] == i_p9_pins[1])
    else $error("port 9 input pin driven or misread");

  a_pa_dir_drive: assert property (wr_done && i_apb.paddr == ADDR_PA_DIR
    |=> o_pa_oe_n == ~$past(i_apb.pwdata[7:0]))
    else $error("port A enables do not follow direction write");

  a_pa_latch_back: assert property (wr_done && i_apb.paddr == ADDR_PA_LATCH
    |=> pa_latch_reg == $past(i_apb.pwdata[7:0]) && o_pa_pins == pa_latch_reg)
    else $error("port A latch write lost");

  a_pa_latch_reset: assert property ($past(i_nrst) == 1'b0 |-> pa_latch_reg == 8'h00 && pa_dir_reg == 8'h00)
    else $error("port A not cleared by reset");

  a_p7_read_level: assert property (setup && i_apb.paddr == ADDR_P7_LEVELS
    |=> o_apb.prdata[7:0] == $past(i_p7_pins) ##1 1'b1)
    else $error("port 7 read does not return pin levels");

  a_unmapped_err: assert property (setup && i_apb.paddr == 12'h000 ##1 access
    |-> o_apb.pslverr && o_apb.pready)
    else $error("unmapped access without error");
endmodule
`default_nettype wire

/* File: testbench/gpdr_pin_env.sv */
// Purpose: Outside circuitry on the port 9 and port A pins.
// Assumes: A released pin shows the outside drive.
// Notes: Resolves each pin level from the device enable.
`timescale 1ns/1ns
`default_nettype none
module gpdr_pin_env #(
  parameter int W = 8
) (
  input wire logic [W-1:0] i_ext,
  input wire logic [W-1:0] i_drv,
  input wire logic [W-1:0] i_oe_n,
  output logic [W-1:0] o_wire
);
  // Device drive wins where its enable is low
  assign o_wire = (i_drv & ~i_oe_n) | (i_ext & i_oe_n);
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Purpose: Self-checking bench for the port data and direction registers.
// Assumes: APB slave answers after one setup cycle.
// Notes: Port pins are resolved by the outside circuitry model.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import gpdr_pkg::*;
  logic clk, nrst, err, en;
  gpdr_apb_req_s req;
  gpdr_apb_rsp_s rsp;
  logic [7:0] p7, ext_a, pa_w, pa_o, pa_oe;
  logic [5:0] ext_9, p9_w, p9_o, p9_oe;
  logic [4:0] p8_o;
  logic [31:0] rd;
  int mismatches, comparisons;

  gpdr_ports u_dut (.i_sys_clk(clk), .i_nrst(nrst), .i_clk_en(en), .i_apb(req), .o_apb(rsp),
    .i_p7_pins(p7), .o_p8_pins(p8_o), .i_p9_pins(p9_w), .o_p9_pins(p9_o), .o_p9_oe_n(p9_oe),
    .i_pa_pins(pa_w), .o_pa_pins(pa_o), .o_pa_oe_n(pa_oe));
  gpdr_pin_env #(.W(6)) u_env9 (.i_ext(ext_9), .i_drv(p9_o), .i_oe_n(p9_oe), .o_wire(p9_w));
  gpdr_pin_env #(.W(8)) u_enva (.i_ext(ext_a), .i_drv(pa_o), .i_oe_n(pa_oe), .o_wire(pa_w));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rw(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {24'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    // Answer is taken at the rising edge where pready is seen high
    while (rsp.pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        mismatches++;
        conclude();
      end
      @(posedge clk);
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    en = 1'b1;
    req = '0;
    p7 = 8'h96;
    ext_9 = 6'h15;
    ext_a = 8'hc3;
    mismatches = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk({26'h0, p9_oe}, 32'h3f);
    chk({24'h0, pa_oe}, 32'hff);
    chk({24'h0, pa_o}, 32'h00);
    chk({27'h0, p8_o}, 32'h00);
    rw(1'b0, ADDR_P9_DIR, 8'h00);
    chk(rd, 32'hff);
    rw(1'b0, ADDR_PA_DIR, 8'h00);
    chk(rd, 32'hff);
    $display("test reset done");
    rw(1'b1, ADDR_P9_LATCH, 8'h2a);
    rw(1'b1, ADDR_P9_DIR, 8'hcf);
    @(negedge clk);
    chk({26'h0, p9_oe}, 32'h30);
    chk({26'h0, p9_o}, 32'h2a);
    rw(1'b0, ADDR_P9_LATCH, 8'h00);
    chk(rd, {24'h0, 2'h3, (6'h2a & 6'h0f) | (ext_9 & 6'h30)});
    $display("test port 9 done");
    rw(1'b1, ADDR_PA_DIR, 8'ha5);
    rw(1'b1, ADDR_PA_LATCH, 8'h3c);
    @(negedge clk);
    chk({24'h0, pa_oe}, 32'h5a);
    rw(1'b0, ADDR_PA_LATCH, 8'h00);
    chk(rd, {24'h0, (8'h3c & 8'ha5) | (ext_a & 8'h5a)});
    rw(1'b1, ADDR_PA_DIR, 8'hff);
    rw(1'b0, ADDR_PA_LATCH, 8'h00);
    chk(rd, 32'h3c);
    $display("test port a done");
    rw(1'b1, ADDR_P7_LEVELS, 8'h00);
    chk({31'h0, err}, 32'h0);
    rw(1'b0, ADDR_P7_LEVELS, 8'h00);
    chk(rd, 32'h96);
    @(posedge clk);
    p7 <= 8'h69;
    rw(1'b0, ADDR_P7_LEVELS, 8'h00);
    chk(rd, 32'h69);
    $display("test port 7 done");
    rw(1'b1, ADDR_P8_LATCH, 8'h1b);
    @(negedge clk);
    chk({27'h0, p8_o}, 32'h1b);
    rw(1'b0, ADDR_P8_LATCH, 8'h00);
    chk(rd, 32'hfb);
    $display("test port 8 done");
    @(posedge clk);
    en <= 1'b0;
    fork
      rw(1'b1, ADDR_PA_LATCH, 8'h81);
      begin
        repeat (4) @(posedge clk);
        chk({24'h0, pa_o}, 32'h3c);
        en <= 1'b1;
      end
    join
    @(negedge clk);
    chk({24'h0, pa_o}, 32'h81);
    $display("test clock enable done");
    rw(1'b1, 12'h000, 8'h55);
    chk({31'h0, err}, 32'h1);
    $display("test unmapped done");
    conclude();
  end
endmodule
`default_nettype wire
